// >>> pkg/dcg_pkg.sv
/*
  constants for the debug command gate: command codes, framing, timing.
  assumes a single core clock at 250 MHz and a fixed bit rate.
*/
package dcg_pkg;
  // command codes
  localparam logic [7:0] DCG_REV_RD   = 8'h00;
  localparam logic [7:0] DCG_CNT_WR   = 8'h01;
  localparam logic [7:0] DCG_STAT_RD  = 8'h02;
  localparam logic [7:0] DCG_CNT_RD   = 8'h03;
  localparam logic [7:0] DCG_CTL_WR   = 8'h04;
  localparam logic [7:0] DCG_CTL_RD   = 8'h05;
  localparam logic [7:0] DCG_PC_WR    = 8'h06;
  localparam logic [7:0] DCG_PC_RD    = 8'h07;
  localparam logic [7:0] DCG_REG_WR   = 8'h08;
  localparam logic [7:0] DCG_REG_RD   = 8'h09;
  localparam logic [7:0] DCG_PMEM_WR  = 8'h0A;
  localparam logic [7:0] DCG_DMEM_RD  = 8'h0D;
  localparam logic [7:0] DCG_CRC_RD   = 8'h0E;
  localparam logic [7:0] DCG_RSVD_0F  = 8'h0F;
  localparam logic [7:0] DCG_STEP     = 8'h10;
  localparam logic [7:0] DCG_EXEC     = 8'h12;
  // peripheral control window, top nibble of the 12-bit address
  localparam logic [3:0] DCG_PERIPH_HI = 4'hF;
  // flash control register address and mass-erase value (arbitrary)
  localparam logic [11:0] DCG_FLASH_CTL_ADDR = 12'hFF8;
  localparam logic [7:0]  DCG_MASS_ERASE     = 8'h63;
  // control register layout and reset
  localparam int          DCG_DBG_MODE_BIT = 7;
  localparam logic [7:0]  DCG_CTL_RST      = 8'h00;
  localparam logic [15:0] DCG_CNT_RST      = 16'h0000;
  // serial framing: 1 start, 8 data lsb first, 1 stop
  localparam int DCG_DATA_BITS = 8;
  localparam int DCG_CLK_MHZ   = 250;
  localparam int DCG_BIT_NS    = 64;
  localparam int DCG_BIT_CYC   = (DCG_BIT_NS * DCG_CLK_MHZ) / 1000;
  localparam int DCG_HALF_CYC  = DCG_BIT_CYC / 2;
  // register-write byte count, zero size meaning 256
  localparam logic [8:0] DCG_SIZE_FULL = 9'h100;
endpackage

// >>> verilog/dcg_byte_rx.sv
/*
  byte receiver for the debug serial pin.
  assumes the pin idles high and runs at the fixed bit rate of the package.
*/
`timescale 1ns/10ps
module dcg_byte_rx (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       pin_in,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  import dcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] sync_q;
  logic       lvl_q, lvl_d;
  logic       busy_q, busy_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] cyc_q, cyc_d;
  logic [7:0] shf_q, shf_d;
  logic       vld_q, vld_d;
  logic [7:0] dat_q, dat_d;

  // a change counts once stages two and three agree
  always_comb begin
    lvl_d  = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
    busy_d = busy_q;
    bit_d  = bit_q;
    cyc_d  = cyc_q;
    shf_d  = shf_q;
    vld_d  = 1'b0;
    dat_d  = dat_q;
    if (!busy_q) begin
      if (lvl_q && !lvl_d) begin
        busy_d = 1'b1;
        bit_d  = 4'h0;
        cyc_d  = 8'(DCG_HALF_CYC);
      end
    end else if (cyc_q != 8'h00) begin
      cyc_d = cyc_q - 8'h01;
    end else begin
      cyc_d = 8'(DCG_BIT_CYC - 1);
      bit_d = bit_q + 4'h1;
      if (bit_q == 4'h0) begin
        if (lvl_q) begin
          busy_d = 1'b0;  // glitch, not a start bit
        end
      end else if (bit_q <= 4'(DCG_DATA_BITS)) begin
        shf_d = {lvl_q, shf_q[7:1]};
      end else begin
        busy_d = 1'b0;
        if (lvl_q) begin
          vld_d = 1'b1;
          dat_d = shf_q;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync_q <= 3'h7;
      lvl_q  <= 1'b1;
      busy_q <= 1'b0;
      bit_q  <= 4'h0;
      cyc_q  <= 8'h00;
      shf_q  <= 8'h00;
      vld_q  <= 1'b0;
      dat_q  <= 8'h00;
    end else begin
      sync_q <= {sync_q[1:0], pin_in};
      lvl_q  <= lvl_d;
      busy_q <= busy_d;
      bit_q  <= bit_d;
      cyc_q  <= cyc_d;
      shf_q  <= shf_d;
      vld_q  <= vld_d;
      dat_q  <= dat_d;
    end
  end

  assign byte_valid = vld_q;
  assign byte_data  = dat_q;
endmodule

// >>> verilog/dcg_gate.sv
/*
  command decoder and permission gate of the on-chip debugger.
  assumes the host frames bytes correctly and answers are sent elsewhere.
*/
// Notes on behaviour
// - every debugger operation arrives as a command byte on the pin
// - outside debug mode only codes 00, 02, 04, 05 are accepted
// - in debug mode all defined codes run unless read protection bars
// - read protection stops code memory contents reaching the host
// - read protection refuses 06, 07, 0A to 0D, 10 to 12
// - under read protection control writes may set, never clear, debug
// - protected register writes land only in F00 to FFF
// - protected writes to flash control carry only mass erase
// - protected register reads give real data only for F00 to FFF
// - 01 writes the counter, debug mode only, not protection gated
// - 02 reads status in any mode, never gated
// - 03 reads the counter, not protection gated
// - 04 writes the control register in any mode
// - 05 reads the control register in any mode, never gated
// - 0E asks for a program memory checksum, not protection gated
// - bytes are one start, eight data lsb first, one stop
// - debug mode follows the control register debug bit
`timescale 1ns/10ps
module dcg_gate (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic                 debug_serial_pin_in,
  output logic                      debug_serial_pin_out,
  output logic                      debug_serial_pin_oe,
  input  wire logic                 read_protect_option,
  input  wire logic [11:0]          reg_rd_addr,
  output logic                      reg_rd_allow,
  output logic                      code_read_block,
  output logic                      cmd_valid,
  output logic [7:0]                cmd_code,
  output logic                      cmd_allowed,
  output logic                      reg_wr_en,
  output logic [11:0]               reg_wr_addr,
  output logic [7:0]                reg_wr_data,
  output logic [7:0]                debugger_control_reg,
  output logic [15:0]               debugger_counter,
  output logic                      debug_mode_bit
);
  import dcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // byte stream from the pin
  logic       rx_vld;
  logic [7:0] rx_byte;

  dcg_byte_rx u_rx (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .pin_in     (debug_serial_pin_in),
    .byte_valid (rx_vld),
    .byte_data  (rx_byte)
  );

  // answers go out through another block, this one never pulls the pin
  assign debug_serial_pin_out = 1'b0;
  assign debug_serial_pin_oe  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    DCG_S_CMD    = 3'h0,
    DCG_S_ADR_HI = 3'h1,
    DCG_S_ADR_LO = 3'h3,
    DCG_S_SIZE   = 3'h2,
    DCG_S_DATA   = 3'h6,
    DCG_S_CTL    = 3'h7,
    DCG_S_CNT_HI = 3'h5,
    DCG_S_CNT_LO = 3'h4
  } dcg_state_e;

  function automatic logic dcg_permit(input logic [7:0] code,
                                      input logic dbg, input logic rp);
    logic ok;
    ok = 1'b0;
    if (!dbg) begin
      ok = (code == DCG_REV_RD) || (code == DCG_STAT_RD) ||
           (code == DCG_CTL_WR) || (code == DCG_CTL_RD);
    end else if ((code <= DCG_CRC_RD) ||
                 (code >= DCG_STEP && code <= DCG_EXEC)) begin
      ok = 1'b1;
      if (rp && ((code == DCG_PC_WR) || (code == DCG_PC_RD) ||
                 (code >= DCG_PMEM_WR && code <= DCG_DMEM_RD) ||
                 (code >= DCG_STEP))) begin
        ok = 1'b0;
      end
    end
    // 0F and 13..FF fall through as refused
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  dcg_state_e  st_q, st_d;
  logic [7:0]  ctl_q, ctl_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0]  cnt_hi_q, cnt_hi_d;
  logic [11:0] adr_q, adr_d;
  logic [8:0]  left_q, left_d;
  logic        wr_ok_q, wr_ok_d;
  logic        cv_q, cv_d;
  logic [7:0]  cc_q, cc_d;
  logic        ca_q, ca_d;
  logic        we_q, we_d;
  logic [11:0] wa_q, wa_d;
  logic [7:0]  wd_q, wd_d;
  logic        rd_ok_q, rd_ok_d;
  logic        rp_q, rp_d;
  logic        dbg;
  logic        land;

  assign dbg = ctl_q[DCG_DBG_MODE_BIT];

  always_comb begin
    st_d     = st_q;
    ctl_d    = ctl_q;
    cnt_d    = cnt_q;
    cnt_hi_d = cnt_hi_q;
    adr_d    = adr_q;
    left_d   = left_q;
    wr_ok_d  = wr_ok_q;
    cv_d     = 1'b0;
    cc_d     = cc_q;
    ca_d     = ca_q;
    we_d     = 1'b0;
    wa_d     = wa_q;
    wd_d     = wd_q;
    land     = 1'b0;
    rp_d     = read_protect_option;
    rd_ok_d  = dbg && (!read_protect_option ||
               reg_rd_addr[11:8] == DCG_PERIPH_HI);
    if (rx_vld) begin
      unique case (st_q)
        DCG_S_CMD: begin
          // every byte here is a command
          cv_d = 1'b1;
          cc_d = rx_byte;
          ca_d = dcg_permit(rx_byte, dbg, rp_q);
          if (rx_byte == DCG_CTL_WR) begin
            st_d = DCG_S_CTL;
          end else if (rx_byte == DCG_CNT_WR) begin
            st_d = DCG_S_CNT_HI;
          end else if (rx_byte == DCG_REG_WR) begin
            st_d    = DCG_S_ADR_HI;
            wr_ok_d = dbg;
          end
          // 02, 03, 05, 0E need no operand here
        end
        DCG_S_CTL: begin
          st_d  = DCG_S_CMD;
          ctl_d = rx_byte;
          if (rp_q && dbg) begin
            ctl_d[DCG_DBG_MODE_BIT] = 1'b1;
          end
        end
        DCG_S_CNT_HI: begin
          st_d     = DCG_S_CNT_LO;
          cnt_hi_d = rx_byte;
        end
        DCG_S_CNT_LO: begin
          st_d = DCG_S_CMD;
          if (dbg) begin
            cnt_d = {cnt_hi_q, rx_byte};
          end
        end
        DCG_S_ADR_HI: begin
          st_d  = DCG_S_ADR_LO;
          adr_d = {rx_byte[3:0], adr_q[7:0]};
        end
        DCG_S_ADR_LO: begin
          st_d  = DCG_S_SIZE;
          adr_d = {adr_q[11:8], rx_byte};
        end
        DCG_S_SIZE: begin
          st_d   = DCG_S_DATA;
          left_d = (rx_byte == 8'h00) ? DCG_SIZE_FULL : {1'b0, rx_byte};
        end
        DCG_S_DATA: begin
          land = wr_ok_q;
          if (rp_q) begin
            land = land && (adr_q[11:8] == DCG_PERIPH_HI);
            if (adr_q == DCG_FLASH_CTL_ADDR) begin
              land = land && (rx_byte == DCG_MASS_ERASE);
            end
          end
          we_d   = land;
          wa_d   = adr_q;
          wd_d   = rx_byte;
          adr_d  = adr_q + 12'h001;
          left_d = left_q - 9'h001;
          if (left_q == 9'h001) begin
            st_d = DCG_S_CMD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q     <= DCG_S_CMD;
      ctl_q    <= DCG_CTL_RST;
      cnt_q    <= DCG_CNT_RST;
      cnt_hi_q <= 8'h00;
      adr_q    <= 12'h000;
      left_q   <= 9'h000;
      wr_ok_q  <= 1'b0;
      cv_q     <= 1'b0;
      cc_q     <= 8'h00;
      ca_q     <= 1'b0;
      we_q     <= 1'b0;
      wa_q     <= 12'h000;
      wd_q     <= 8'h00;
      rd_ok_q  <= 1'b0;
      rp_q     <= 1'b1;
    end else begin
      st_q     <= st_d;
      ctl_q    <= ctl_d;
      cnt_q    <= cnt_d;
      cnt_hi_q <= cnt_hi_d;
      adr_q    <= adr_d;
      left_q   <= left_d;
      wr_ok_q  <= wr_ok_d;
      cv_q     <= cv_d;
      cc_q     <= cc_d;
      ca_q     <= ca_d;
      we_q     <= we_d;
      wa_q     <= wa_d;
      wd_q     <= wd_d;
      rd_ok_q  <= rd_ok_d;
      rp_q     <= rp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection held from reset until sampled, safer than open
  assign code_read_block      = rp_q;
  assign reg_rd_allow         = rd_ok_q;
  assign cmd_valid            = cv_q;
  assign cmd_code             = cc_q;
  assign cmd_allowed          = ca_q;
  assign reg_wr_en            = we_q;
  assign reg_wr_addr          = wa_q;
  assign reg_wr_data          = wd_q;
  assign debugger_control_reg = ctl_q;
  assign debugger_counter     = cnt_q;
  assign debug_mode_bit       = dbg;
endmodule

// >>> test/dcg_host.sv
/*
  host side of the debug serial pin: sends framed bytes.
  assumes the pin has a pull-up, so idle and released read high.
*/
`timescale 1ns/10ps
module dcg_host (
  input  wire logic core_clk,
  output logic      pin
);
  import dcg_pkg::*;
  initial pin = 1'b1;
  // start, eight data lsb first, stop; idle stays high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge core_clk);
      pin = f[i];
      repeat (DCG_BIT_CYC - 1) @(negedge core_clk);
    end
  endtask
endmodule

// >>> test/dcg_gate_chk.sv
/*
  assertions on the gate's ports.
  assumes one clock domain and commands spaced a byte apart.
*/
`timescale 1ns/10ps
module dcg_gate_chk
  import dcg_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        read_protect_option,
  input wire logic [11:0] reg_rd_addr,
  input wire logic        reg_rd_allow,
  input wire logic        code_read_block,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic        cmd_allowed,
  input wire logic        reg_wr_en,
  input wire logic [11:0] reg_wr_addr,
  input wire logic [7:0]  reg_wr_data,
  input wire logic [7:0]  debugger_control_reg,
  input wire logic        debug_mode_bit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////
  sequence s_prot_cmd;
    cmd_valid && code_read_block;
  endsequence
  a_mode_bit: assert property (
    debug_mode_bit == debugger_control_reg[DCG_DBG_MODE_BIT])
    else $error("mode bit differs from control bit");
  a_prot_copy: assert property (
    1'b1 |=> code_read_block == $past(read_protect_option))
    else $error("protect flag not tracking option");
  a_keep_debug: assert property (
    code_read_block && debug_mode_bit |=> debug_mode_bit)
    else $error("debug mode cleared under protect");
  a_rsvd_refused: assert property (
    cmd_valid && (cmd_code == DCG_RSVD_0F || cmd_code > DCG_EXEC)
    |-> !cmd_allowed) else $error("reserved code allowed");
  a_normal_subset: assert property (
    cmd_valid && !debug_mode_bit
    && !(cmd_code inside {8'h00, 8'h02, 8'h04, 8'h05}) |-> !cmd_allowed)
    else $error("debug-only code allowed in normal mode");
  a_prot_refuse: assert property (
    s_prot_cmd ##0 (cmd_code inside {8'h06, 8'h07, [8'h0A:8'h0D],
    [8'h10:8'h12]}) |-> !cmd_allowed) else $error("barred code allowed");
  a_rd_window: assert property (
    read_protect_option && reg_rd_addr[11:8] != DCG_PERIPH_HI
    |=> !reg_rd_allow) else $error("protected read allowed");
  a_wr_window: assert property (
    reg_wr_en && code_read_block |-> reg_wr_addr[11:8] == DCG_PERIPH_HI)
    else $error("protected write outside window");
  a_flash_erase: assert property (
    reg_wr_en && code_read_block && reg_wr_addr == DCG_FLASH_CTL_ADDR
    |-> reg_wr_data == DCG_MASS_ERASE) else $error("flash value passed");
  a_valid_pulse: assert property (
    cmd_valid |=> !cmd_valid [*8]) else $error("command pulse too long");
endmodule
bind dcg_gate dcg_gate_chk u_chk (.core_clk(core_clk), .rstn(rstn),
  .read_protect_option(read_protect_option), .reg_rd_addr(reg_rd_addr),
  .reg_rd_allow(reg_rd_allow), .code_read_block(code_read_block),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_allowed(cmd_allowed),
  .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
  .reg_wr_data(reg_wr_data), .debug_mode_bit(debug_mode_bit),
  .debugger_control_reg(debugger_control_reg));

// >>> test/debug_command_gate_test.sv
/*
  testbench of the gate with a mode and permission model.
  assumes the host model in dcg_host and the bound checker.
*/
`timescale 1ns/10ps
module debug_command_gate_test;
  import dcg_pkg::*;
  logic        core_clk = 1'b0;
  logic        rstn, rp, hp, po, oe, ra, cb, cv, ca, we, dm;
  logic [11:0] addr, wa_o, wa;
  logic [7:0]  code, wd_o, wd, ctl, r8;
  logic [15:0] cnt, v;
  int          num_errors = 0, total_checks = 0, nv = 0, nw = 0, dbg = 0;
  wire         pin = hp & ~(oe & ~po);
  always #2 core_clk = ~core_clk;
  dcg_host hst (.core_clk(core_clk), .pin(hp));
  dcg_gate uut (.core_clk(core_clk), .rstn(rstn),
    .debug_serial_pin_in(pin), .debug_serial_pin_out(po),
    .debug_serial_pin_oe(oe), .read_protect_option(rp), .reg_rd_addr(addr),
    .reg_rd_allow(ra), .code_read_block(cb), .cmd_valid(cv),
    .cmd_code(code), .cmd_allowed(ca), .reg_wr_en(we), .reg_wr_addr(wa_o),
    .reg_wr_data(wd_o), .debugger_control_reg(ctl),
    .debugger_counter(cnt), .debug_mode_bit(dm));
  always @(posedge core_clk) begin
    if (cv === 1'b1) nv++;
    if (we === 1'b1) begin
      nw++;
      wa = wa_o;
      wd = wd_o;
    end
  end
  ////////////////////
  function automatic logic ok(int c, int d, int p);
    if (c == 8'h0F || c > 8'h12) return 1'b0;
    if (d == 0) return c == 0 || c == 2 || c == 4 || c == 5;
    if (p != 0 && (c == 6 || c == 7 || (c >= 8'h0A && c <= 8'h0D)
        || c >= 8'h10)) return 1'b0;
    return 1'b1;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic put(input logic [7:0] b);
    hst.send(b);
    repeat (8) @(negedge core_clk);
  endtask
  task automatic cmd(input logic [7:0] c);
    int n;
    n = nv;
    hst.send(c);
    for (int k = 0; k < 40 && nv == n; k++) @(negedge core_clk);
    chk(16'(nv - n), 16'h0001);
    chk({8'h00, code}, {8'h00, c});
    chk({15'h0, ca}, {15'h0, ok(c, dbg, int'(rp))});
  endtask
  task automatic rw(input logic [11:0] a, input logic [7:0] d, input int e);
    int n;
    n = nw;
    cmd(DCG_REG_WR);
    put({4'h0, a[11:8]});
    put(a[7:0]);
    put(8'h01);
    put(d);
    chk(16'(nw - n), 16'(e));
    if (e != 0) begin
      chk({4'h0, wa}, {4'h0, a});
      chk({8'h00, wd}, {8'h00, d});
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    conclude();
  end
  initial begin
    rstn = 1'b0;
    rp = 1'b0;
    addr = 12'h000;
    r8 = 8'($urandom(32'h65b22d12));
    repeat (16) @(negedge core_clk);
    chk({2'b00, oe, po, cb, cv, ra, we, ctl}, 16'h0800);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    // modes: normal, debug, debug with protect
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 8'h14; c++)
        if (c != 1 && c != 4 && c != 8) cmd(8'(c));
      cmd(8'(8'h13 + $urandom % 237));
      $display("code sweep %0d done", m);
      if (m == 0) begin
        cmd(DCG_CTL_WR);
        put(8'h80);
        dbg = 1;
      end
      if (m == 1) rp = 1'b1;
    end
    cmd(DCG_CTL_WR);
    put(8'h00);
    chk({15'h0, dm}, 16'h0001);
    chk({8'h00, ctl}, 16'h0080);
    rw(12'hF23, r8, 1);
    rw(12'h123, r8, 0);
    rw(DCG_FLASH_CTL_ADDR, DCG_MASS_ERASE, 1);
    rw(DCG_FLASH_CTL_ADDR, 8'h12, 0);
    addr = 12'hF40;
    repeat (3) @(negedge core_clk);
    chk({15'h0, ra}, 16'h0001);
    addr = 12'h340;
    repeat (3) @(negedge core_clk);
    chk({15'h0, ra}, 16'h0000);
    // only a reset leaves protected debug mode
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({14'h0, cb, dm}, 16'h0002);
    rstn = 1'b1;
    dbg = 0;
    repeat (4) @(negedge core_clk);
    cmd(DCG_CTL_WR);
    put(8'h80);
    dbg = 1;
    chk({15'h0, dm}, 16'h0001);
    rp = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({15'h0, ra}, 16'h0001);
    $display("protect tests done");
    v = 16'($urandom);
    cmd(DCG_CNT_WR);
    put(v[15:8]);
    put(v[7:0]);
    chk(cnt, v);
    cmd(DCG_CTL_WR);
    put(8'h00);
    dbg = 0;
    chk({15'h0, dm}, 16'h0000);
    cmd(DCG_CNT_WR);
    put(~v[15:8]);
    put(~v[7:0]);
    chk(cnt, v);
    rw(12'hF23, r8, 0);
    $display("mode exit tests done");
    conclude();
  end
endmodule
